//--- logic/rotx_exec.sv
/*
  execute block for rotate through extend, the three stack returns, decimal subtract with extend
  and set byte on condition, reached as an APB slave.
  assumes software loads opcode, operands and stacked words, then writes the start bit; memory
  and stack traffic is done outside, steered by the action bits in the execution status register.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module rotx_exec
  import rotx_exec_pkg::*;
(
  input wire logic pclk, // 125 MHz clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error on unmapped address
);
  import rotx_exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic [32:0] rot_step(input logic [31:0] v, input logic x, input logic [1:0] sz,
                                           input logic left);
    logic [31:0] n;
    logic o;
    n = v;
    o = 1'b0;
    case (sz)
      SIZE_BYTE:
      begin
        o = left ? v[7] : v[0];
        n[7:0] = left ? {v[6:0], x} : {x, v[7:1]};
      end
      SIZE_WORD, SIZE_MEM:
      begin
        o = left ? v[15] : v[0];
        n[15:0] = left ? {v[14:0], x} : {x, v[15:1]};
      end
      default:
      begin
        o = left ? v[31] : v[0];
        n = left ? {v[30:0], x} : {x, v[31:1]};
      end
    endcase
    return {o, n};
  endfunction

  function automatic logic sized_top(input logic [31:0] v, input logic [1:0] sz);
    return (sz == SIZE_BYTE) ? v[7] : ((sz == SIZE_LONG) ? v[31] : v[15]);
  endfunction

  function automatic logic sized_zero(input logic [31:0] v, input logic [1:0] sz);
    return (sz == SIZE_BYTE) ? (v[7:0] == '0) : ((sz == SIZE_LONG) ? (v == '0) : (v[15:0] == '0));
  endfunction

  function automatic logic mem_alterable(input logic [2:0] mode, input logic [2:0] rg);
    return ((mode >= MODE_INDIRECT) && (mode <= MODE_INDEXED))
        || ((mode == MODE_EXT) && ((rg == EXT_ABS_SHORT) || (rg == EXT_ABS_LONG)));
  endfunction

  function automatic logic cond_true(input logic [3:0] code, input logic [FLAG_TOP:0] f);
    logic c;
    logic v;
    logic z;
    logic n;
    logic t;
    c = f[FLAG_C];
    v = f[FLAG_V];
    z = f[FLAG_Z];
    n = f[FLAG_N];
    t = 1'b0;
    unique case (code)
      COND_TRUE: t = 1'b1;
      COND_FALSE: t = 1'b0;
      COND_HIGHER: t = !c && !z;
      COND_LOWER_SAME: t = c || z;
      COND_CARRY_CLEAR: t = !c;
      COND_CARRY_SET: t = c;
      COND_NOT_EQUAL: t = !z;
      COND_EQUAL: t = z;
      COND_OVERFLOW_CLEAR: t = !v;
      COND_OVERFLOW_SET: t = v;
      COND_PLUS: t = !n;
      COND_MINUS: t = n;
      COND_GREATER_EQUAL: t = (n == v);
      COND_LESS_THAN: t = (n != v);
      COND_GREATER_THAN: t = (n == v) && !z;
      COND_LESS_EQUAL: t = z || (n != v);
    endcase
    return t;
  endfunction

  // packed decimal d - s - x, returns borrow then result byte
  function automatic logic [8:0] dec_sub(input logic [7:0] d, input logic [7:0] s, input logic x);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, x};
    if (lo[4])
    begin
      lo[3:0] = lo[3:0] - BCD_ADJUST;
    end
    hi = {1'b0, d[7:4]} - {1'b0, s[7:4]} - {4'h0, lo[4]};
    if (hi[4])
    begin
      hi[3:0] = hi[3:0] - BCD_ADJUST;
    end
    return {hi[4], hi[3:0], lo[3:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // state

  state_type state_q, state_d;
  logic [15:0] opcode_q, opcode_d;
  logic [31:0] dst_q, dst_d;
  logic [31:0] src_q, src_d;
  logic [15:0] status_q, status_d;
  logic [15:0] stack_word_q, stack_word_d;
  logic [31:0] stack_pc_q, stack_pc_d;
  logic [31:0] result_q, result_d;
  logic [31:0] pc_q, pc_d;
  logic [7:0] exec_q, exec_d;
  logic [5:0] rot_cnt_q, rot_cnt_d;
  logic rot_left_q, rot_left_d;
  logic [1:0] rot_size_q, rot_size_d;
  logic [31:0] prdata_q, prdata_d;

  logic wr_acc;
  logic start_go;
  logic addr_hit;
  logic is_rot_reg;
  logic is_rot_mem;
  logic is_dec_sub;
  logic is_set_cond;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [5:0] rot_count;
  logic [1:0] rot_size;
  logic [32:0] step;
  logic [8:0] dec_out;
  logic cond_hit;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // decode of the loaded opcode

  always_comb
  begin
    ea_mode = opcode_q[5:3];
    ea_reg = opcode_q[2:0];
    is_rot_reg = (opcode_q[15:12] == GROUP_ROTATE) && (opcode_q[4:3] == ROT_REG_TAG)
              && (opcode_q[7:6] != SIZE_MEM);
    is_rot_mem = (opcode_q[15:9] == ROT_MEM_PREFIX) && (opcode_q[7:6] == SIZE_MEM);
    is_dec_sub = (opcode_q[15:12] == GROUP_DEC_SUB) && (opcode_q[8:4] == DEC_SUB_TAG);
    is_set_cond = (opcode_q[15:12] == GROUP_SET_COND) && (opcode_q[7:6] == SIZE_MEM);
    rot_size = is_rot_mem ? SIZE_WORD : opcode_q[7:6];
    if (is_rot_mem)
    begin
      rot_count = COUNT_ONE;
    end
    else if (opcode_q[5])
    begin
      rot_count = src_q[5:0];
    end
    else
    begin
      rot_count = (opcode_q[11:9] == 3'h0) ? COUNT_FOR_ZERO_FIELD : {3'h0, opcode_q[11:9]};
    end
    step = rot_step(result_q, status_q[FLAG_X], rot_size_q, rot_left_q);
    dec_out = dec_sub(dst_q[7:0], src_q[7:0], status_q[FLAG_X]);
    cond_hit = cond_true(opcode_q[11:8], status_q[FLAG_TOP:0]);
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // register writes and execution

  always_comb
  begin
    state_d = state_q;
    opcode_d = opcode_q;
    dst_d = dst_q;
    src_d = src_q;
    status_d = status_q;
    stack_word_d = stack_word_q;
    stack_pc_d = stack_pc_q;
    result_d = result_q;
    pc_d = pc_q;
    exec_d = exec_q;
    rot_cnt_d = rot_cnt_q;
    rot_left_d = rot_left_q;
    rot_size_d = rot_size_q;
    wr_acc = psel && penable && pwrite;
    start_go = wr_acc && (paddr == ADDR_CTRL) && pwdata[CTRL_START_BIT] && (state_q == ST_IDLE);
    if (wr_acc)
    begin
      case (paddr)
        ADDR_OPCODE: opcode_d = pwdata[15:0];
        ADDR_DST: dst_d = pwdata;
        ADDR_SRC: src_d = pwdata;
        ADDR_STATUS_WORD: status_d = pwdata[15:0];
        ADDR_STACK_WORD: stack_word_d = pwdata[15:0];
        ADDR_STACK_PC: stack_pc_d = pwdata;
        default: ;
      endcase
    end
    if (start_go)
    begin
      exec_d = '0;
      exec_d[EXB_DONE] = 1'b1;
      if (opcode_q == OP_RET_EXC)
      begin
        if (status_q[SUPER_BIT])
        begin
          status_d = stack_word_q;
          pc_d = stack_pc_q;
          exec_d[EXB_PC_LOAD] = 1'b1;
        end
        else
        begin
          exec_d[EXB_TRAP] = 1'b1;
        end
      end
      else if (opcode_q == OP_RET_RESTORE)
      begin
        status_d[FLAG_TOP:0] = stack_word_q[FLAG_TOP:0];
        pc_d = stack_pc_q;
        exec_d[EXB_PC_LOAD] = 1'b1;
      end
      else if (opcode_q == OP_RET_SUB)
      begin
        pc_d = stack_pc_q;
        exec_d[EXB_PC_LOAD] = 1'b1;
      end
      else if (is_rot_reg || (is_rot_mem && mem_alterable(ea_mode, ea_reg)))
      begin
        result_d = dst_q;
        rot_left_d = opcode_q[8];
        rot_size_d = rot_size;
        rot_cnt_d = rot_count;
        exec_d[EXB_MEM_READ] = is_rot_mem;
        exec_d[EXB_MEM_WRITE] = is_rot_mem;
        if (rot_count == '0)
        begin
          status_d[FLAG_C] = status_q[FLAG_X];
          status_d[FLAG_V] = 1'b0;
          status_d[FLAG_N] = sized_top(dst_q, rot_size);
          status_d[FLAG_Z] = sized_zero(dst_q, rot_size);
        end
        else
        begin
          exec_d[EXB_DONE] = 1'b0;
          state_d = ST_ROTATE;
        end
      end
      else if (is_dec_sub)
      begin
        result_d = {dst_q[31:8], dec_out[7:0]};
        status_d[FLAG_C] = dec_out[8];
        status_d[FLAG_X] = dec_out[8];
        if (dec_out[7:0] != '0)
        begin
          status_d[FLAG_Z] = 1'b0;
        end
        exec_d[EXB_PREDEC] = opcode_q[3];
        exec_d[EXB_MEM_READ] = opcode_q[3];
        exec_d[EXB_MEM_WRITE] = opcode_q[3];
      end
      else if (is_set_cond && ((ea_mode == MODE_DATA_REG) || mem_alterable(ea_mode, ea_reg)))
      begin
        result_d = {dst_q[31:8], cond_hit ? BYTE_ONES : 8'h00};
        exec_d[EXB_MEM_READ] = (ea_mode != MODE_DATA_REG);
        exec_d[EXB_MEM_WRITE] = (ea_mode != MODE_DATA_REG);
      end
      else
      begin
        exec_d[EXB_ILLEGAL] = 1'b1;
      end
    end
    if (state_q == ST_ROTATE)
    begin
      result_d = step[31:0];
      status_d[FLAG_X] = step[32];
      rot_cnt_d = rot_cnt_q - COUNT_ONE;
      if (rot_cnt_q == COUNT_ONE)
      begin
        status_d[FLAG_C] = step[32];
        status_d[FLAG_V] = 1'b0;
        status_d[FLAG_N] = sized_top(step[31:0], rot_size_q);
        status_d[FLAG_Z] = sized_zero(step[31:0], rot_size_q);
        exec_d[EXB_DONE] = 1'b1;
        state_d = ST_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      opcode_q <= '0;
      dst_q <= '0;
      src_q <= '0;
      status_q <= STATUS_RESET;
      stack_word_q <= '0;
      stack_pc_q <= '0;
      result_q <= '0;
      pc_q <= '0;
      exec_q <= '0;
      rot_cnt_q <= '0;
      rot_left_q <= 1'b0;
      rot_size_q <= SIZE_BYTE;
    end
    else
    begin
      state_q <= state_d;
      opcode_q <= opcode_d;
      dst_q <= dst_d;
      src_q <= src_d;
      status_q <= status_d;
      stack_word_q <= stack_word_d;
      stack_pc_q <= stack_pc_d;
      result_q <= result_d;
      pc_q <= pc_d;
      exec_q <= exec_d;
      rot_cnt_q <= rot_cnt_d;
      rot_left_q <= rot_left_d;
      rot_size_q <= rot_size_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // apb read path, data captured in the setup cycle

  always_comb
  begin
    addr_hit = 1'b1;
    prdata_d = prdata_q;
    case (paddr)
      ADDR_CTRL: prdata_d = '0;
      ADDR_OPCODE: prdata_d = {16'h0000, opcode_q};
      ADDR_DST: prdata_d = dst_q;
      ADDR_SRC: prdata_d = src_q;
      ADDR_STATUS_WORD: prdata_d = {16'h0000, status_q};
      ADDR_STACK_WORD: prdata_d = {16'h0000, stack_word_q};
      ADDR_STACK_PC: prdata_d = stack_pc_q;
      ADDR_RESULT: prdata_d = result_q;
      ADDR_PC: prdata_d = pc_q;
      ADDR_EXEC: prdata_d = {24'h000000, exec_q[7:1], state_q == ST_ROTATE};
      default:
      begin
        addr_hit = 1'b0;
        prdata_d = '0;
      end
    endcase
    if (!(psel && !penable))
    begin
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking chk_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  rot_flag_end_a: assert property ((state_q == ST_ROTATE) && (rot_cnt_q == COUNT_ONE) |=>
    !status_q[FLAG_V] && (status_q[FLAG_Z] == sized_zero(result_q, rot_size_q))
    && (status_q[FLAG_N] == sized_top(result_q, rot_size_q)))
    else $error("rotate end flags wrong");
  rot_carry_ext_a: assert property ((state_q == ST_ROTATE) && (rot_cnt_q == COUNT_ONE) |=>
    status_q[FLAG_C] == status_q[FLAG_X])
    else $error("carry and extend differ after rotate");
  rot_zero_count_a: assert property (start_go && is_rot_reg && (rot_count == '0) |=>
    (status_q[FLAG_C] == $past(status_q[FLAG_X])) && $stable(status_q[FLAG_X]) && (result_q == $past(dst_q)))
    else $error("zero count rotate altered extend or result");
  rot_eight_steps_a: assert property (start_go && is_rot_reg && !opcode_q[5]
    && (opcode_q[11:9] == 3'h0) |=> (state_q == ST_ROTATE) [*8] ##1 (state_q == ST_IDLE))
    else $error("zero count field did not rotate eight times");
  rot_mem_mode_a: assert property (start_go && is_rot_mem && !mem_alterable(ea_mode, ea_reg) |=>
    exec_q[EXB_ILLEGAL] && (state_q == ST_IDLE))
    else $error("memory rotate accepted a bad mode");
  user_trap_a: assert property (start_go && (opcode_q == OP_RET_EXC) && !status_q[SUPER_BIT] |=>
    exec_q[EXB_TRAP] && $stable(pc_q) && $stable(status_q))
    else $error("privileged return ran in user state");
  restore_super_a: assert property (start_go && (opcode_q == OP_RET_RESTORE) |=>
    (status_q[15:8] == $past(status_q[15:8])) && (status_q[FLAG_TOP:0] == $past(stack_word_q[FLAG_TOP:0]))
    && (pc_q == $past(stack_pc_q)))
    else $error("flag restore touched supervisor half");
  sub_return_a: assert property (start_go && (opcode_q == OP_RET_SUB) |=>
    $stable(status_q) && (pc_q == $past(stack_pc_q)))
    else $error("subroutine return changed flags");
  dec_borrow_a: assert property (start_go && is_dec_sub |=>
    (status_q[FLAG_X] == status_q[FLAG_C]) && (!$past(status_q[FLAG_Z]) || (result_q[7:0] == '0)
    || !status_q[FLAG_Z]))
    else $error("decimal subtract flags wrong");
  set_byte_a: assert property (start_go && is_set_cond && (ea_mode == MODE_DATA_REG) |=>
    (result_q[7:0] == ($past(cond_hit) ? BYTE_ONES : 8'h00)) && $stable(status_q))
    else $error("set on condition byte wrong");
  set_mem_read_a: assert property (start_go && is_set_cond && (ea_mode != MODE_DATA_REG)
    && mem_alterable(ea_mode, ea_reg) |=> exec_q[EXB_MEM_READ] && exec_q[EXB_MEM_WRITE])
    else $error("memory set lacks read before write");

  rot_long_c: cover property (start_go && is_rot_reg && (rot_size == SIZE_LONG) ##1 (state_q == ST_ROTATE));
  ret_exc_c: cover property (start_go && (opcode_q == OP_RET_EXC) && status_q[SUPER_BIT]);
  dec_borrow_c: cover property (start_go && is_dec_sub ##1 status_q[FLAG_C]);
  set_true_c: cover property (start_go && is_set_cond && cond_hit);
endmodule

//--- logic/rotx_exec_pkg.sv
/*
  constants, field layouts and state codes for the rotate-through-extend, return, decimal subtract
  and set-on-condition execute block.
  assumes a single 125 MHz clock and an APB master that reaches the block's registers.
*/
//
// Overview of operation
// - extended rotate: negative from result top bit, zero if result zero, overflow cleared
// - extended rotate: carry takes last bit out; zero count loads carry from extend
// - extended rotate: extend takes last bit out; zero count leaves extend alone
// - immediate count field gives 1 to 7 directly, value 0 means 8
// - register count selector takes count from named data register modulo 64
// - direction bit 0 rotates right, 1 rotates left, register and memory forms
// - register rotate size field: 00 byte, 01 word, 10 long
// - register rotate decoded from top nibble 1110 and bits 4..3 equal 10
// - memory rotate decoded from bits 15..9 1110010 and bits 7..6 11
// - memory rotate accepts only memory alterable addressing modes
// - return from exception traps when attempted in user state
// - return from exception pops whole status word, then program counter
// - return restoring flags pops condition flags only, then program counter, unprivileged
// - return from subroutine pops program counter, flags untouched
// - decimal subtract: destination minus source minus extend, packed byte decimal
// - decimal subtract: zero cleared if nonzero else kept; carry is borrow; extend copies
// - decimal subtract mode bit: 0 register to register, 1 memory predecrement both
// - decimal subtract decoded from top nibble 1000 and bits 8..4 10000
// - set on condition writes all ones if true, zeros otherwise, flags untouched
// - condition field codes for true, false, higher, carry, equality, overflow, sign, compares
// - set on condition decoded from top nibble 0101, bits 7..6 11, data alterable only
// - set on condition to memory reads the destination byte before writing
// - left extended rotate: top bit out to carry and extend, old extend enters bottom
// - right extended rotate: bottom bit out to carry and extend, old extend enters top
// - memory rotate moves one bit position on a word operand only
package rotx_exec_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPCODE = 8'h04;
  localparam logic [7:0] ADDR_DST = 8'h08;
  localparam logic [7:0] ADDR_SRC = 8'h0C;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'h10;
  localparam logic [7:0] ADDR_STACK_WORD = 8'h14;
  localparam logic [7:0] ADDR_STACK_PC = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1C;
  localparam logic [7:0] ADDR_PC = 8'h20;
  localparam logic [7:0] ADDR_EXEC = 8'h24;
  localparam int CTRL_START_BIT = 0;
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_X = 4;
  localparam int FLAG_TOP = 4;
  localparam int SUPER_BIT = 13;
  localparam logic [15:0] STATUS_RESET = 16'h2000;
  localparam int EXB_BUSY = 0;
  localparam int EXB_DONE = 1;
  localparam int EXB_TRAP = 2;
  localparam int EXB_ILLEGAL = 3;
  localparam int EXB_MEM_READ = 4;
  localparam int EXB_MEM_WRITE = 5;
  localparam int EXB_PREDEC = 6;
  localparam int EXB_PC_LOAD = 7;
  localparam logic [15:0] OP_RET_EXC = 16'h4E73;
  localparam logic [15:0] OP_RET_RESTORE = 16'h4E77;
  localparam logic [15:0] OP_RET_SUB = 16'h4E75;
  localparam logic [3:0] GROUP_ROTATE = 4'hE;
  localparam logic [3:0] GROUP_DEC_SUB = 4'h8;
  localparam logic [3:0] GROUP_SET_COND = 4'h5;
  localparam logic [1:0] ROT_REG_TAG = 2'h2;
  localparam logic [6:0] ROT_MEM_PREFIX = 7'h72;
  localparam logic [4:0] DEC_SUB_TAG = 5'h10;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_MEM = 2'h3;
  localparam logic [2:0] MODE_DATA_REG = 3'h0;
  localparam logic [2:0] MODE_INDIRECT = 3'h2;
  localparam logic [2:0] MODE_INDEXED = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_SHORT = 3'h0;
  localparam logic [2:0] EXT_ABS_LONG = 3'h1;
  localparam logic [5:0] COUNT_FOR_ZERO_FIELD = 6'h08;
  localparam logic [5:0] COUNT_ONE = 6'h01;
  localparam logic [3:0] BCD_ADJUST = 4'h6;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] COND_TRUE = 4'h0;
  localparam logic [3:0] COND_FALSE = 4'h1;
  localparam logic [3:0] COND_HIGHER = 4'h2;
  localparam logic [3:0] COND_LOWER_SAME = 4'h3;
  localparam logic [3:0] COND_CARRY_CLEAR = 4'h4;
  localparam logic [3:0] COND_CARRY_SET = 4'h5;
  localparam logic [3:0] COND_NOT_EQUAL = 4'h6;
  localparam logic [3:0] COND_EQUAL = 4'h7;
  localparam logic [3:0] COND_OVERFLOW_CLEAR = 4'h8;
  localparam logic [3:0] COND_OVERFLOW_SET = 4'h9;
  localparam logic [3:0] COND_PLUS = 4'hA;
  localparam logic [3:0] COND_MINUS = 4'hB;
  localparam logic [3:0] COND_GREATER_EQUAL = 4'hC;
  localparam logic [3:0] COND_LESS_THAN = 4'hD;
  localparam logic [3:0] COND_GREATER_THAN = 4'hE;
  localparam logic [3:0] COND_LESS_EQUAL = 4'hF;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ROTATE = 2'b10} state_type;
endpackage

//--- test/stack_model.sv
/*
  stack frame model: holds the stacked status word and the return address
  assumes the bench loads a frame before each return instruction
*/
`timescale 1ns/1ps
module stack_model(
  input wire logic pclk, // clock
  input wire logic load, // take a new frame
  input wire logic [47:0] frame, // status word above return address
  output logic [15:0] top_word, // word popped first
  output logic [31:0] top_pc // address popped second
);
  always_ff @(posedge pclk)
  begin
    if (load)
    begin
      {top_word, top_pc} <= frame;
    end
  end
endmodule

//--- test/rotx_exec_test.sv
/*
  self-checking bench for rotx_exec over apb
  assumes the stack model supplies the frames that the returns pop
*/
`timescale 1ns/1ps
module rotx_exec_test;
  import rotx_exec_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [23:0] MODES = 24'o22650374;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [47:0] frame = 0;
  logic [15:0] sw;
  logic [31:0] spc;
  logic [64:0] notes[$];
  logic [64:0] nt;
  int n_errors = 0, total_checks = 0, seed = 63331, cyc = 0;
  always #4 pclk = ~pclk;
  rotx_exec uut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  stack_model stk(.pclk(pclk), .load(ld), .frame(frame), .top_word(sw), .top_pc(spc));
////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      report_and_stop();
    end
    if (psel && penable && pready && !pwrite && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt[64] || nt[63:32] != 0)
      begin
        cmp($sformatf("data_at_%h", paddr), nt[31:0] & nt[63:32], prdata & nt[63:32]);
        cmp("slave_error", {31'h0, nt[64]}, {31'h0, pslverr});
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err = 0);
    notes.push_back({err, m, e});
    apb(0, a, 32'h0);
  endtask
  task automatic newframe();
    frame <= {16'($random(seed)) & 16'hA71F, 32'($random(seed))};
    ld <= 1;
    @(posedge pclk);
    ld <= 0;
    @(posedge pclk);
  endtask
  // loads operands and stacked words, starts, then polls until the block settles
  task automatic exec(input logic [15:0] op, input logic [31:0] d, input logic [31:0] s, input logic [15:0] st);
    int k = 0;
    wr(ADDR_STATUS_WORD, {16'h0, st});
    wr(ADDR_DST, d);
    wr(ADDR_SRC, s);
    wr(ADDR_STACK_WORD, {16'h0, sw});
    wr(ADDR_STACK_PC, spc);
    wr(ADDR_OPCODE, {16'h0, op});
    wr(ADDR_CTRL, 32'h1);
    do
    begin
      rd(ADDR_EXEC, 32'h0, 32'h0);
      k++;
    end
    while ((q[0] || q[3:1] == 0) && k < 40);
  endtask
  // returns {x, n, z, v, c, result}
  function automatic logic [36:0] rox(input logic [31:0] d, input logic [1:0] sz, input logic lf,
    input logic [6:0] n, input logic x);
    logic [31:0] m, v;
    logic c;
    int w;
    w = 8 << sz;
    m = (w == 32) ? ALL : (32'h1 << w) - 1;
    v = d & m;
    c = x;
    for (int i = 0; i < n; i++)
    begin
      c = lf ? v[w - 1] : v[0];
      v = lf ? (((v << 1) | {31'h0, x}) & m) : ((v >> 1) | ({31'h0, x} << (w - 1)));
      x = c;
    end
    return {x, v[w - 1], v == 0, 1'b0, c, (d & ~m) | v};
  endfunction
  function automatic logic cnd(input logic [3:0] sel, input logic [4:0] f);
    logic c, v, z, n;
    logic [15:0] t;
    {n, z, v, c} = f[3:0];
    t = {z | (n ^ v), !z && n == v, n != v, n == v, n, !n, v, !v, z, !z, c, !c, c | z, !c && !z, 1'b0, 1'b1};
    return t[sel];
  endfunction
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] op, st, e;
    logic [31:0] d, s;
    logic [36:0] r;
    int a, b;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_STATUS_WORD, {16'h0, STATUS_RESET}, 32'hFFFF);
    rd(8'hF0, 32'h0, ALL, 1);
    newframe();
    for (int i = 0; i < 14; i++)
    begin
      d = $random(seed);
      s = (i == 0) ? 32'h40 : $random(seed);
      st = 16'($random(seed)) & 16'hA71F;
      op = {4'hE, (i == 1) ? 3'h0 : 3'($random(seed)), 1'($random(seed)), 2'($unsigned($random(seed)) % 3),
        1'(i == 0), 2'b10, 3'(i)};
      op[5] = (i > 1) ? 1'($random(seed)) : op[5];
      r = rox(d, op[7:6], op[8], op[5] ? {1'b0, s[5:0]} : (op[11:9] == 0 ? 7'd8 : {4'h0, op[11:9]}), st[4]);
      exec(op, d, s, st);
      rd(ADDR_RESULT, r[31:0], ALL);
      rd(ADDR_STATUS_WORD, {16'h0, st[15:5], r[36:32]}, 32'hFFFF);
    end
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      st = 16'($random(seed)) & 16'hA71F;
      op = {7'h72, 1'(i), 2'b11, MODES[23 - 6 * i -: 6]};
      r = rox(d, 2'h1, op[8], 7'd1, st[4]);
      exec(op, d, 32'h0, st);
      if (i < 2)
      begin
        rd(ADDR_RESULT, r[31:0], 32'hFFFF);
        rd(ADDR_STATUS_WORD, {16'h0, st[15:5], r[36:32]}, 32'hFFFF);
      end
      else
        rd(ADDR_EXEC, 32'h8, 32'h8);
    end
    for (int i = 0; i < 4; i++)
    begin
      newframe();
      st = (16'($random(seed)) & 16'h871F) | ((i == 1 || i == 2) ? 16'h0 : 16'h2000);
      op = (i < 2) ? OP_RET_EXC : (i == 2 ? OP_RET_RESTORE : OP_RET_SUB);
      exec(op, 32'h0, 32'h0, st);
      e = (i == 0) ? sw : (i == 2 ? {st[15:5], sw[4:0]} : st);
      rd(ADDR_STATUS_WORD, {16'h0, e}, 32'hFFFF);
      if (i == 1)
        rd(ADDR_EXEC, 32'h4, 32'h4);
      else
        rd(ADDR_PC, spc, ALL);
    end
    for (int i = 0; i < 8; i++)
    begin
      a = $unsigned($random(seed)) % 100;
      b = $unsigned($random(seed)) % 100;
      d = $random(seed);
      d[7:0] = {4'(a / 10), 4'(a % 10)};
      s = {24'h0, 4'(b / 10), 4'(b % 10)};
      st = 16'($random(seed)) & 16'hA71F;
      op = {4'h8, 3'(i), 5'h10, 1'(i >> 2), 3'($random(seed))};
      a = a - b - int'(st[4]);
      b = (a < 0) ? 1 : 0;
      a = a + 100 * b;
      exec(op, d, s, st);
      rd(ADDR_RESULT, {d[31:8], 4'(a / 10), 4'(a % 10)}, ALL);
      rd(ADDR_STATUS_WORD, {16'h0, st[15:5], b[0], 1'b0, st[2] & (a == 0), 1'b0, b[0]}, 32'hFFF5);
      rd(ADDR_EXEC, {25'h0, 1'(i >> 2), 6'h0}, 32'h40);
    end
    for (int i = 0; i < 18; i++)
    begin
      d = $random(seed);
      st = 16'($random(seed)) & 16'hA71F;
      op = {4'h5, 4'(i), 2'b11, i > 15 ? 6'o11 : (i % 2 == 1 ? 6'o23 : 6'o04)};
      exec(op, d, 32'h0, st);
      if (i > 15)
        rd(ADDR_EXEC, 32'h8, 32'h8);
      else
      begin
        rd(ADDR_RESULT, {d[31:8], {8{cnd(4'(i), st[4:0])}}}, ALL);
        rd(ADDR_STATUS_WORD, {16'h0, st}, 32'hFFFF);
        rd(ADDR_EXEC, {26'h0, {2{1'(i % 2)}}, 4'h0}, 32'h30);
      end
    end
    report_and_stop();
  end
endmodule
